// File: tb/pcs_host.sv
// host-side issuer of commands toward the sequencer
`timescale 1ns/1ns
module pcs_host (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic req,
  input wire logic [7:0] op,
  input wire logic playback_busy_n,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic [7:0] cmd_arg
);
  logic pend_q, pend_d, send_d, starts, late;
  logic [7:0] op_q, op_d;
  logic [23:0] age_q, age_d;
  // ---------------------------------------------
  // chain window: hold a late chained command until idle
  // ---------------------------------------------
  always_comb begin
    starts = ((op_q & pcs_pkg::OP_PLAY_MASK) == pcs_pkg::OP_PLAY)
      || (op_q == pcs_pkg::OP_START) || (op_q == pcs_pkg::OP_SILENCE);
    late = !playback_busy_n && (age_q >= 24'(pcs_pkg::WINDOW_CYC));
    pend_d = pend_q;
    op_d = op_q;
    send_d = 1'b0;
    age_d = late ? age_q : age_q + 24'h000001;
    if (pend_q && (op_q == pcs_pkg::OP_LOOP_SET) && late) begin
      pend_d = 1'b0;
    end else if (pend_q && !(starts && late)) begin
      send_d = 1'b1;
      pend_d = 1'b0;
      if (starts) age_d = 24'h000000;
    end
    if (req) begin
      pend_d = 1'b1;
      op_d = op;
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pend_q <= 1'b0;
      op_q <= 8'h00;
      age_q <= 24'h000000;
      cmd_valid <= 1'b0;
      cmd_byte <= 8'h00;
    end else begin
      pend_q <= pend_d;
      op_q <= op_d;
      age_q <= age_d;
      cmd_valid <= send_d;
      if (send_d) cmd_byte <= op_q;
    end
  end
  assign cmd_arg = ~cmd_byte;
endmodule

// File: tb/tb.sv
// self-checking bench of the playback command sequencer
`timescale 1ns/1ns
module tb;
  logic sys_clk = 0, resetn = 0, hw_reset_n = 1, req = 0, phrase_done = 0;
  logic [7:0] op = 8'h00, cmd_byte, cmd_arg;
  logic cmd_valid, osc_run, playback_busy_n, next_command_ready_n, loop_armed;
  int err_count = 0, total_checks = 0;
  logic [9:0] rows [4] = '{{8'h40, 2'b01}, {8'h00, 2'b11}, {8'h20, 2'b01}, {8'h03, 2'b11}};
  pcs_host i_host (.sys_clk(sys_clk), .resetn(resetn), .req(req), .op(op),
    .playback_busy_n(playback_busy_n), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .cmd_arg(cmd_arg));
  pcs_top i_dut (.sys_clk(sys_clk), .resetn(resetn), .hw_reset_n(hw_reset_n),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_arg(cmd_arg),
    .phrase_done(phrase_done), .osc_run(osc_run), .playback_busy_n(playback_busy_n),
    .next_command_ready_n(next_command_ready_n), .loop_armed(loop_armed));
  // ---------------------------------------------
  // clock, tasks
  // ---------------------------------------------
  initial forever #25 sys_clk = ~sys_clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] c);
    @(posedge sys_clk);
    req <= 1'b1;
    op <= c;
    @(posedge sys_clk);
    req <= 1'b0;
    cyc(6);
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #50_000_000;
    err_count++;
    report_and_stop;
  end
  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    #1;
    chk(osc_run, 1'b0);
    foreach (rows[i]) begin
      send(rows[i][9:2]);
      chk(osc_run, rows[i][1]);
      chk(playback_busy_n, rows[i][0]);
    end
    send(8'h40);
    chk(playback_busy_n, 1'b0);
    chk(next_command_ready_n, 1'b0);
    cyc(39980);
    chk(next_command_ready_n, 1'b0);
    cyc(40);
    chk(next_command_ready_n, 1'b1);
    chk(playback_busy_n, 1'b0);
    @(posedge sys_clk);
    phrase_done <= 1'b1;
    @(posedge sys_clk);
    phrase_done <= 1'b0;
    cyc(239980);
    chk(playback_busy_n, 1'b0);
    cyc(40);
    chk(playback_busy_n, 1'b1);
    send(8'h44);
    cyc(40000);
    send(8'h70);
    chk(loop_armed, 1'b1);
    send(8'h78);
    chk(loop_armed, 1'b0);
    send(8'h48);
    chk(next_command_ready_n, 1'b0);
    chk(playback_busy_n, 1'b0);
    @(posedge sys_clk);
    hw_reset_n <= 1'b0;
    cyc(6);
    chk(osc_run, 1'b0);
    @(posedge sys_clk);
    hw_reset_n <= 1'b1;
    cyc(6);
    chk(osc_run, 1'b0);
    send(8'h00);
    chk(osc_run, 1'b1);
    @(posedge sys_clk);
    hw_reset_n <= 1'b0;
    cyc(6);
    chk(osc_run, 1'b0);
    chk(playback_busy_n, 1'b1);
    report_and_stop;
  end
endmodule

// File: verilog/pcs_pkg.sv
// package: constants and types for the playback command sequencer
package pcs_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned CMD_BUSY_US = 2000;
  localparam int unsigned TAIL_MS = 12;
  localparam int unsigned WINDOW_MS = 10;
  localparam int unsigned CMD_BUSY_CYC = (CLK_HZ / 1000000) * CMD_BUSY_US;
  localparam int unsigned TAIL_CYC = (CLK_HZ / 1000) * TAIL_MS;
  localparam int unsigned WINDOW_CYC = (CLK_HZ / 1000) * WINDOW_MS;
  localparam int unsigned CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
  localparam logic [7:0] OP_EXACT = 8'hFF;
  localparam logic [7:0] OP_POWER_UP = 8'h00;
  localparam logic [7:0] OP_POWER_UP_MASK = 8'hFC;
  localparam logic [7:0] OP_POWER_DOWN = 8'h20;
  localparam logic [7:0] OP_PLAY = 8'h40;
  localparam logic [7:0] OP_PLAY_MASK = 8'hF3;
  localparam logic [7:0] OP_STOP = 8'h60;
  localparam logic [7:0] OP_START = 8'h50;
  localparam logic [7:0] OP_SILENCE = 8'h48;
  localparam logic [7:0] OP_LOOP_SET = 8'h70;
  localparam logic [7:0] OP_LOOP_CLR = 8'h78;
  typedef enum logic [2:0] {
    PCS_OFF, PCS_IDLE, PCS_CMD, PCS_PLAY, PCS_TAIL
  } pcs_state_t;
endpackage

// File: verilog/pcs_sync.sv
// two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ns
module pcs_sync (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign sync_out = sync_q;
endmodule

// File: verilog/pcs_top.sv
// top: playback command sequencer with busy and next-command-ready outputs
// Contract
// - oscillator halted after power-on until power-up
// - hardware reset during idle enters power-down
// - busy low: command time, phrase, 12 ms
// - ready low length depends on next command
// - busy low while processing or playing
`timescale 1ns/1ns
module pcs_top (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic hw_reset_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic [7:0] cmd_arg,
  input wire logic phrase_done,
  output logic osc_run,
  output logic playback_busy_n,
  output logic next_command_ready_n,
  output logic loop_armed
);
  // ---------------------------------------------
  // command decode
  // ---------------------------------------------
  logic hwr_n;
  pcs_sync u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .async_in(hw_reset_n),
    .sync_out(hwr_n)
  );

  function automatic logic is_op(input logic [7:0] b, input logic [7:0] op,
                                 input logic [7:0] mask);
    is_op = ((b & mask) == op);
  endfunction

  logic c_pwr_up;
  logic c_pwr_dn;
  logic c_play;
  logic c_stop;
  logic c_chain;
  logic c_lset;
  logic c_lclr;
  assign c_pwr_up = cmd_valid && is_op(cmd_byte, pcs_pkg::OP_POWER_UP,
                    pcs_pkg::OP_POWER_UP_MASK);
  assign c_pwr_dn = cmd_valid && is_op(cmd_byte, pcs_pkg::OP_POWER_DOWN, pcs_pkg::OP_EXACT);
  assign c_play = cmd_valid && is_op(cmd_byte, pcs_pkg::OP_PLAY, pcs_pkg::OP_PLAY_MASK);
  assign c_stop = cmd_valid && is_op(cmd_byte, pcs_pkg::OP_STOP, pcs_pkg::OP_EXACT);
  assign c_chain = c_play || (cmd_valid && (is_op(cmd_byte, pcs_pkg::OP_START, pcs_pkg::OP_EXACT)
                   || is_op(cmd_byte, pcs_pkg::OP_SILENCE, pcs_pkg::OP_EXACT)));
  assign c_lset = cmd_valid && is_op(cmd_byte, pcs_pkg::OP_LOOP_SET, pcs_pkg::OP_EXACT);
  assign c_lclr = cmd_valid && is_op(cmd_byte, pcs_pkg::OP_LOOP_CLR, pcs_pkg::OP_EXACT);

  // ---------------------------------------------
  // sequencer
  // ---------------------------------------------
  pcs_pkg::pcs_state_t st_q;
  pcs_pkg::pcs_state_t st_d;
  logic [pcs_pkg::CNT_W-1:0] cnt_q;
  logic [pcs_pkg::CNT_W-1:0] cnt_d;
  logic [pcs_pkg::CNT_W-1:0] win_q;
  logic [pcs_pkg::CNT_W-1:0] win_d;
  logic pend_q;
  logic pend_d;
  logic loop_q;
  logic loop_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    win_d = (win_q != pcs_pkg::CNT_ZERO) ? win_q - pcs_pkg::CNT_ONE : win_q;
    pend_d = pend_q;
    loop_d = loop_q;
    if (c_lclr) loop_d = 1'b0;
    case (st_q)
      pcs_pkg::PCS_OFF: begin
        if (c_pwr_up) st_d = pcs_pkg::PCS_IDLE;
      end
      pcs_pkg::PCS_IDLE: begin
        if (c_pwr_dn) st_d = pcs_pkg::PCS_OFF;
        else if (c_chain) begin
          st_d = pcs_pkg::PCS_CMD;
          cnt_d = 24'(pcs_pkg::CMD_BUSY_CYC);
        end
      end
      pcs_pkg::PCS_CMD: begin
        cnt_d = cnt_q - pcs_pkg::CNT_ONE;
        if (c_stop) st_d = pcs_pkg::PCS_IDLE;
        else if (cnt_q == pcs_pkg::CNT_ONE) begin
          st_d = pcs_pkg::PCS_PLAY;
          win_d = 24'(pcs_pkg::WINDOW_CYC);
          pend_d = 1'b0;
        end
      end
      pcs_pkg::PCS_PLAY: begin
        if (c_stop) begin
          st_d = pcs_pkg::PCS_IDLE;
          loop_d = 1'b0;
        end else begin
          if (c_lset && win_q != pcs_pkg::CNT_ZERO) loop_d = 1'b1;
          if (c_chain && win_q != pcs_pkg::CNT_ZERO) pend_d = 1'b1;
          if (phrase_done) begin
            if (loop_q || pend_q) begin
              win_d = 24'(pcs_pkg::WINDOW_CYC);
              pend_d = 1'b0;
            end else begin
              st_d = pcs_pkg::PCS_TAIL;
              cnt_d = 24'(pcs_pkg::TAIL_CYC);
            end
          end
        end
      end
      pcs_pkg::PCS_TAIL: begin
        cnt_d = cnt_q - pcs_pkg::CNT_ONE;
        if (cnt_q == pcs_pkg::CNT_ONE) st_d = pcs_pkg::PCS_IDLE;
      end
      default: st_d = pcs_pkg::PCS_OFF;
    endcase
    if (!hwr_n) begin
      st_d = pcs_pkg::PCS_OFF;
      loop_d = 1'b0;
      pend_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= pcs_pkg::PCS_OFF;
      cnt_q <= pcs_pkg::CNT_ZERO;
      win_q <= pcs_pkg::CNT_ZERO;
      pend_q <= 1'b0;
      loop_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      win_q <= win_d;
      pend_q <= pend_d;
      loop_q <= loop_d;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  logic busy_n_q;
  logic ready_n_q;
  logic osc_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy_n_q <= 1'b1;
      ready_n_q <= 1'b1;
      osc_q <= 1'b0;
    end else begin
      busy_n_q <= (st_d == pcs_pkg::PCS_IDLE) || (st_d == pcs_pkg::PCS_OFF);
      ready_n_q <= !((st_d == pcs_pkg::PCS_CMD) || pend_d);
      osc_q <= (st_d != pcs_pkg::PCS_OFF);
    end
  end
  assign playback_busy_n = busy_n_q;
  assign next_command_ready_n = ready_n_q;
  assign osc_run = osc_q;
  assign loop_armed = loop_q;

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  property p_osc_off;
    @(posedge sys_clk) disable iff (!resetn)
    (st_q == pcs_pkg::PCS_OFF) |-> !osc_run;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("osc runs in power-down");
  property p_hwreset;
    @(posedge sys_clk) disable iff (!resetn)
    !hwr_n |=> (st_q == pcs_pkg::PCS_OFF);
  endproperty
  a_hwreset: assert property (p_hwreset) else $error("reset missed power-down");
  property p_tail;
    @(posedge sys_clk) disable iff (!resetn)
    (st_q == pcs_pkg::PCS_TAIL && cnt_q == pcs_pkg::CNT_ONE && hwr_n) |=> playback_busy_n;
  endproperty
  a_tail: assert property (p_tail) else $error("busy not released after tail");
  property p_busy;
    @(posedge sys_clk) disable iff (!resetn)
    (st_q == pcs_pkg::PCS_PLAY) |-> !playback_busy_n;
  endproperty
  a_busy: assert property (p_busy) else $error("busy high during playback");
  property p_ready;
    @(posedge sys_clk) disable iff (!resetn)
    (st_q == pcs_pkg::PCS_CMD && st_d == pcs_pkg::PCS_CMD) |=> !next_command_ready_n;
  endproperty
  a_ready: assert property (p_ready) else $error("ready high while processing");

  // chained command inside the window holds ready low
  property p_chain_ready;
    @(posedge sys_clk) disable iff (!resetn)
    (st_q == pcs_pkg::PCS_PLAY && c_chain && win_q != pcs_pkg::CNT_ZERO && !c_stop
     && !phrase_done && hwr_n) |=> !next_command_ready_n;
  endproperty
  a_chain_ready: assert property (p_chain_ready) else $error("chain left ready high");

  property p_osc_on;
    @(posedge sys_clk) disable iff (!resetn)
    (st_q != pcs_pkg::PCS_OFF) |-> osc_run;
  endproperty
  a_osc_on: assert property (p_osc_on) else $error("osc stopped while powered");

  property p_idle_busy;
    @(posedge sys_clk) disable iff (!resetn)
    (st_q == pcs_pkg::PCS_IDLE) |-> playback_busy_n;
  endproperty
  a_idle_busy: assert property (p_idle_busy) else $error("busy low while idle");

  property p_cmd_busy;
    @(posedge sys_clk) disable iff (!resetn)
    (st_q == pcs_pkg::PCS_CMD) |-> !playback_busy_n;
  endproperty
  a_cmd_busy: assert property (p_cmd_busy) else $error("busy high in command time");

  property p_loop_drop;
    @(posedge sys_clk) disable iff (!resetn)
    !hwr_n |=> !loop_armed;
  endproperty
  a_loop_drop: assert property (p_loop_drop) else $error("loop kept over reset");

  c_play_seen: cover property (@(posedge sys_clk) st_q == pcs_pkg::PCS_PLAY);
  c_chain_seen: cover property (@(posedge sys_clk) pend_q);
  c_tail_seen: cover property (@(posedge sys_clk) st_q == pcs_pkg::PCS_TAIL);
  c_loop_seen: cover property (@(posedge sys_clk) loop_q);
endmodule
